// ===== hw/cpc_params.svh
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// clock and settling time
`define CPC_CLK_PERIOD_NS   10
`define CPC_SETTLE_TIME_NS  5000
`define CPC_SETTLE_CYCLES   ((`CPC_SETTLE_TIME_NS + `CPC_CLK_PERIOD_NS - 1) / `CPC_CLK_PERIOD_NS)

// register word indices; byte address is four times the index
`define CPC_IDX_W           10
`define CPC_CTRL_IDX        10'h09A
`define CPC_IRQ_STAT_IDX    10'h0A0
`define CPC_IRQ_MASK_IDX    10'h0A1

// control/status field layout
`define CPC_MODE_HI         7
`define CPC_MODE_LO         6
`define CPC_THR_BIT         1
`define CPC_RDY_BIT         0
`define CPC_REG_W           8
`define CPC_CTRL_RST        8'h00

// interrupt event layout
`define CPC_EV_W            4
`define CPC_EV_RDY          0
`define CPC_EV_THR          1
`define CPC_EV_PON          2
`define CPC_EV_POFF         3
`define CPC_EV_RST          4'h0

// bus encodings
`define CPC_HTRANS_NONSEQ_BIT 1
`define CPC_DATA_W          32

`endif

// ===== hw/cpc_pkg.sv
`default_nettype none

`include "cpc_params.svh"

package cpc_pkg;

   typedef enum logic [1:0]
   {
      CPC_MODE_OFF  = 2'b00,
      CPC_MODE_CONV = 2'b01,
      CPC_MODE_AUTO = 2'b10,
      CPC_MODE_ON   = 2'b11
   } cpc_mode_t;

   // accepted address phase, held for the data phase
   typedef struct packed
   {
      logic [`CPC_IDX_W-1:0] idx;
      logic                  write;
      logic                  valid;
   } cpc_bus_req_t;

   // analog levels after synchronisation
   typedef struct packed
   {
      logic above;
      logic settled;
   } cpc_analog_t;

endpackage

`default_nettype wire

// ===== hw/cpc_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "cpc_params.svh"

module cpc_top
   import cpc_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES    = `CPC_SETTLE_CYCLES,
   parameter bit          USE_EXT_SETTLED  = 1'b0
)
(
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [`CPC_DATA_W-1:0] hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic [`CPC_DATA_W-1:0]      hrdata,
   output logic                        hresp,
   input  wire logic                   supply_above_threshold,
   input  wire logic                   converter_en,
   input  wire logic                   pump_settled_in,
   output logic                        pump_enable,
   output logic                        irq
);

   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES);

   // input synchronisers
   // comparator and settled level come from the analog domain; a change is taken
   // only once the second and third stages agree, which also filters one-cycle glitches
   logic [2:0]  above_sync_reg;
   logic [2:0]  settled_sync_reg;
   cpc_analog_t analog_reg;
   cpc_analog_t analog_next;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         above_sync_reg   <= 3'h0;
         settled_sync_reg <= 3'h0;
      end
      else
      begin
         above_sync_reg   <= {above_sync_reg[1:0], supply_above_threshold};
         settled_sync_reg <= {settled_sync_reg[1:0], pump_settled_in};
      end
   end

   assign analog_next.above   = (above_sync_reg[1] == above_sync_reg[2]) ?
                                above_sync_reg[2] : analog_reg.above;
   assign analog_next.settled = (settled_sync_reg[1] == settled_sync_reg[2]) ?
                                settled_sync_reg[2] : analog_reg.settled;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         analog_reg <= '0;
      else
         analog_reg <= analog_next;
   end

   // bus address phase
   cpc_bus_req_t req_reg;
   cpc_bus_req_t req_next;
   logic         addr_take;

   assign addr_take      = hsel & hready & htrans[`CPC_HTRANS_NONSEQ_BIT];
   assign req_next.idx   = haddr[`CPC_IDX_W+1:2];
   assign req_next.write = hwrite;
   assign req_next.valid = addr_take;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req_reg <= '0;
      else
         req_reg <= req_next;
   end

   // data-phase write strobes
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;

   assign wr_ctrl = req_reg.valid & req_reg.write & (req_reg.idx == `CPC_CTRL_IDX);
   assign wr_stat = req_reg.valid & req_reg.write & (req_reg.idx == `CPC_IRQ_STAT_IDX);
   assign wr_mask = req_reg.valid & req_reg.write & (req_reg.idx == `CPC_IRQ_MASK_IDX);

   // mode field
   cpc_mode_t mode_reg;
   cpc_mode_t mode_next;

   assign mode_next = wr_ctrl ? cpc_mode_t'(hwdata[`CPC_MODE_HI:`CPC_MODE_LO]) : mode_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_reg <= CPC_MODE_OFF;
      else
         mode_reg <= mode_next;
   end

   // pump enable
   logic pump_en_reg;
   logic pump_en_next;
   logic supply_low;

   assign supply_low = ~analog_reg.above;

   always_comb
   begin
      case (mode_reg)
         CPC_MODE_ON:   pump_en_next = 1'b1;
         CPC_MODE_AUTO: pump_en_next = supply_low;
         CPC_MODE_CONV: pump_en_next = supply_low & converter_en;
         CPC_MODE_OFF:  pump_en_next = 1'b0;
         default:       pump_en_next = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pump_en_reg <= 1'b0;
      else
         pump_en_reg <= pump_en_next;
   end

   assign pump_enable = pump_en_reg;

   // ready status
   // ready is gated by the next enable, so it drops on the same edge as the
   // pump and can never report a pump that is not being run
   logic             ready_reg;
   logic             ready_next;
   logic [CNT_W-1:0] settle_cnt_reg;
   logic [CNT_W-1:0] settle_cnt_next;
   logic             settle_done;

   assign settle_done     = (settle_cnt_reg == SETTLE_LAST);
   assign settle_cnt_next = !pump_en_reg ? '0 :
                            settle_done  ? settle_cnt_reg :
                            settle_cnt_reg + CNT_W'(1);
   assign ready_next      = pump_en_next & (USE_EXT_SETTLED ? analog_reg.settled : settle_done);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         settle_cnt_reg <= '0;
         ready_reg      <= 1'b0;
      end
      else
      begin
         settle_cnt_reg <= settle_cnt_next;
         ready_reg      <= ready_next;
      end
   end

   // interrupt events
   logic                 above_d_reg;
   logic                 ready_d_reg;
   logic                 pump_d_reg;
   logic [`CPC_EV_W-1:0] ev_set;
   logic [`CPC_EV_W-1:0] stat_reg;
   logic [`CPC_EV_W-1:0] stat_next;
   logic [`CPC_EV_W-1:0] mask_reg;
   logic [`CPC_EV_W-1:0] mask_next;
   logic [`CPC_EV_W-1:0] stat_clr;
   logic                 irq_reg;
   logic                 irq_next;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         above_d_reg <= 1'b0;
         ready_d_reg <= 1'b0;
         pump_d_reg  <= 1'b0;
      end
      else
      begin
         above_d_reg <= analog_reg.above;
         ready_d_reg <= ready_reg;
         pump_d_reg  <= pump_en_reg;
      end
   end

   assign ev_set[`CPC_EV_RDY]  = ready_reg & ~ready_d_reg;
   assign ev_set[`CPC_EV_THR]  = analog_reg.above ^ above_d_reg;
   assign ev_set[`CPC_EV_PON]  = pump_en_reg & ~pump_d_reg;
   assign ev_set[`CPC_EV_POFF] = ~pump_en_reg & pump_d_reg;

   // a new event in the clearing cycle survives the clear
   assign stat_clr  = wr_stat ? hwdata[`CPC_EV_W-1:0] : `CPC_EV_RST;
   assign stat_next = (stat_reg & ~stat_clr) | ev_set;
   assign mask_next = wr_mask ? hwdata[`CPC_EV_W-1:0] : mask_reg;
   assign irq_next  = |(stat_next & mask_next);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat_reg <= `CPC_EV_RST;
         mask_reg <= `CPC_EV_RST;
         irq_reg  <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         irq_reg  <= irq_next;
      end
   end

   assign irq = irq_reg;

   // read path
   // read data is sampled at the address phase, so a read issued right behind a
   // write to the same register returns the value from before that write
   logic [`CPC_REG_W-1:0]  ctrl_view;
   logic [`CPC_DATA_W-1:0] rdata_sel;
   logic [`CPC_DATA_W-1:0] rdata_reg;
   logic [`CPC_DATA_W-1:0] rdata_next;
   logic [`CPC_IDX_W-1:0]  rd_idx;

   always_comb
   begin
      ctrl_view                                = `CPC_CTRL_RST;
      ctrl_view[`CPC_MODE_HI:`CPC_MODE_LO]     = mode_reg;
      ctrl_view[`CPC_THR_BIT]                  = analog_reg.above;
      ctrl_view[`CPC_RDY_BIT]                  = ready_reg;
   end

   assign rd_idx     = haddr[`CPC_IDX_W+1:2];
   assign rdata_sel  = (rd_idx == `CPC_CTRL_IDX)     ? `CPC_DATA_W'(ctrl_view) :
                       (rd_idx == `CPC_IRQ_STAT_IDX) ? `CPC_DATA_W'(stat_reg)  :
                       (rd_idx == `CPC_IRQ_MASK_IDX) ? `CPC_DATA_W'(mask_reg)  :
                       '0;
   assign rdata_next = (addr_take & ~hwrite) ? rdata_sel : '0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdata_reg <= '0;
      else
         rdata_reg <= rdata_next;
   end

   assign hrdata = rdata_reg;

   // zero-wait slave: always ready, always OKAY
   logic ready_out_reg;
   logic resp_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ready_out_reg <= 1'b1;
         resp_reg      <= 1'b0;
      end
      else
      begin
         ready_out_reg <= 1'b1;
         resp_reg      <= 1'b0;
      end
   end

   assign hreadyout = ready_out_reg;
   assign hresp     = resp_reg;

   // assertions
   logic ctrl_rd_take;

   assign ctrl_rd_take = addr_take & ~hwrite & (rd_idx == `CPC_CTRL_IDX);

   force_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == CPC_MODE_ON) ##1 (mode_reg == CPC_MODE_ON) |-> pump_enable [*1] ##1 pump_enable)
      else $error("pump not held on in forced mode");

   auto_supply_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == CPC_MODE_AUTO) |=> (pump_enable == !$past(analog_reg.above)))
      else $error("auto mode pump enable does not follow supply");

   auto_conv_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == CPC_MODE_CONV) |=>
         (pump_enable == ($past(converter_en) && !$past(analog_reg.above))))
      else $error("converter mode pump enable wrong");

   mode_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == CPC_MODE_OFF) [*2] |-> !pump_enable ##1 !ready_reg)
      else $error("pump or ready active in off mode");

   thr_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_rd_take |=> (hrdata[`CPC_THR_BIT] == $past(analog_reg.above)))
      else $error("threshold bit does not match supply");

   ready_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(pump_enable) |-> !ready_reg ##1 (!$past(ctrl_rd_take) || !hrdata[`CPC_RDY_BIT]))
      else $error("ready stays set after pump off");

   mode_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> (mode_reg == $past(hwdata[`CPC_MODE_HI:`CPC_MODE_LO])))
      else $error("mode field not written");

   settle_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(ready_reg) |-> USE_EXT_SETTLED || ($past(settle_cnt_reg) == SETTLE_LAST))
      else $error("ready before settling count done");

   irq_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq == |(stat_reg & mask_reg))
      else $error("interrupt output mismatch");

   ready_needs_pump_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ready_reg |-> pump_enable)
      else $error("ready set while pump off");

   event_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ev_set != '0) |=> ((stat_reg & $past(ev_set)) == $past(ev_set)))
      else $error("status event lost to a clear");

   pump_on_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(pump_enable) |=> stat_reg[`CPC_EV_PON])
      else $error("pump on event not recorded");

endmodule

`default_nettype wire

// ===== sim/cpc_analog_model.sv
`timescale 1ns/100ps
`default_nettype none

module cpc_analog_model
#(
   parameter int SETTLE = 4
)
(
   input  wire logic hclk,
   input  wire logic supply_hi,
   input  wire logic pump_enable,
   output logic      supply_above_threshold,
   output logic      pump_settled_in
);
   int unsigned run_cnt = 0;

   // comparator is a plain level of the supply
   assign supply_above_threshold = supply_hi;

   // the pump needs some cycles of enable before it is steady; off drops it at once
   always @(posedge hclk)
      run_cnt <= pump_enable ? run_cnt + 1 : 0;
   assign pump_settled_in = pump_enable && (run_cnt >= SETTLE);
endmodule

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none

`include "cpc_params.svh"

module testbench;
   import cpc_pkg::*;
   localparam int SETTLE = 4;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, pump_enable, irq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic        supply_hi = 0, conv = 0, above, settled;
   int          num_errors = 0, comparisons = 0, cyc = 0;
   int          mode, exp_pump;

   cpc_top #(.SETTLE_CYCLES(SETTLE), .USE_EXT_SETTLED(1'b0)) i_cpc_top
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .supply_above_threshold(above), .converter_en(conv), .pump_settled_in(settled),
      .pump_enable(pump_enable), .irq(irq)
   );

   cpc_analog_model #(.SETTLE(SETTLE)) i_cpc_analog_model
   (
      .hclk(hclk), .supply_hi(supply_hi), .pump_enable(pump_enable),
      .supply_above_threshold(above), .pump_settled_in(settled)
   );

   initial
   begin
      forever #5 hclk = ~hclk;
   end

   task automatic end_sim();
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // a hang is cut short here and counted
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask

   // one single AHB transfer; waits on hready in both phases
   task automatic ahb(input bit wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {20'h0, idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   initial
   begin
      void'($urandom(32'h77788ED9));
      wait_cyc(2);
      hresetn <= 1'b1;
      ahb(0, `CPC_CTRL_IDX, 32'h0);
      chk("ctrl_reset", rd, 32'h0);
      chk("pump_reset", pump_enable, 1'b0);
      ahb(1, 10'h001, 32'hFFFFFFFF);
      ahb(0, 10'h001, 32'h0);
      chk("unmapped", rd, 32'h0);
      // every mode against random supply and converter state
      for (int i = 0; i < 32; i++)
      begin
         mode = i % 4;
         @(posedge hclk);
         supply_hi <= 1'($urandom);
         conv      <= 1'($urandom);
         ahb(1, `CPC_CTRL_IDX, ($urandom & 32'hFFFFFF3F) | (mode << 6));
         wait_cyc(16);
         exp_pump = (mode == 3) || (mode == 2 && !supply_hi) || (mode == 1 && conv && !supply_hi);
         chk("pump_enable", pump_enable, exp_pump);
         ahb(0, `CPC_CTRL_IDX, 32'h0);
         chk("ctrl_read", rd, (mode << 6) | (supply_hi << 1) | exp_pump);
      end
      // settling counter restarts on each enable
      ahb(1, `CPC_CTRL_IDX, 32'h00);
      ahb(1, `CPC_CTRL_IDX, 32'hC0);
      ahb(0, `CPC_CTRL_IDX, 32'h0);
      chk("ready_settling", rd[0], 1'b0);
      wait_cyc(SETTLE + 2);
      ahb(0, `CPC_CTRL_IDX, 32'h0);
      chk("ready_steady", rd[0], 1'b1);
      // interrupt on pump turning on: raise, mask, clear
      ahb(1, `CPC_IRQ_MASK_IDX, 32'h0);
      ahb(1, `CPC_CTRL_IDX, 32'h00);
      ahb(1, `CPC_IRQ_STAT_IDX, 32'hF);
      ahb(1, `CPC_IRQ_MASK_IDX, 32'h4);
      wait_cyc(3);
      chk("irq_idle", irq, 1'b0);
      ahb(1, `CPC_CTRL_IDX, 32'hC0);
      wait_cyc(3);
      chk("irq_raised", irq, 1'b1);
      ahb(0, `CPC_IRQ_STAT_IDX, 32'h0);
      chk("stat_pump_on", rd & 32'h4, 32'h4);
      ahb(1, `CPC_IRQ_MASK_IDX, 32'h0);
      wait_cyc(3);
      chk("irq_masked", irq, 1'b0);
      ahb(1, `CPC_IRQ_MASK_IDX, 32'h4);
      ahb(1, `CPC_IRQ_STAT_IDX, 32'h4);
      wait_cyc(3);
      chk("irq_cleared", irq, 1'b0);
      ahb(0, `CPC_IRQ_STAT_IDX, 32'h0);
      chk("stat_ready_rose", rd & 32'h5, 32'h1);
      chk("hresp", hresp, 1'b0);
      chk("hreadyout", hreadyout, 1'b1);
      // reset in mid-run drops the pump and the mode field
      @(posedge hclk);
      hresetn <= 1'b0;
      wait_cyc(2);
      chk("pump_mid_reset", pump_enable, 1'b0);
      chk("irq_mid_reset", irq, 1'b0);
      hresetn <= 1'b1;
      ahb(0, `CPC_CTRL_IDX, 32'h0);
      chk("ctrl_mid_reset", rd & 32'hC1, 32'h0);
      end_sim();
   end
endmodule

`default_nettype wire
